// ==== dv/two_wire_far_end.sv ====
`timescale 1ns/100ps

// ==========================================================
// Far-side slave: wired-AND lines with pull-ups, ack and stretch.
module two_wire_far_end (
	input  wire logic       DEV_SDA_OE,
	input  wire logic       DEV_SCL_OE,
	input  wire logic       NACK,
	input  wire logic       STRETCH,
	input  wire logic       BUS_COND,
	output logic            SDA,
	output logic            SCL,
	output logic [7:0]      BYTE,
	output int              N_BYTES
);
	logic       sda_oe = 1'b0;
	logic       scl_oe = 1'b0;
	logic [3:0] cnt    = 4'h0;

	// Released lines read high through the pull-ups.
	// BUS_COND pulls SDA low by itself to make conditions or collisions.
	assign SDA = !(DEV_SDA_OE || sda_oe || BUS_COND);
	assign SCL = !(DEV_SCL_OE || scl_oe);

	initial begin
		BYTE = 8'h00;
		N_BYTES = 0;
	end

	// A start condition restarts the bit count.
	always @(negedge SDA) begin
		if (SCL)
			cnt = 4'h0;
	end

	always @(posedge SCL) begin
		if (cnt < 4'h8)
			BYTE = {BYTE[6:0], SDA};
		cnt = cnt + 4'h1;
	end

	// Ack on the ninth bit, optional clock stretch after each fall.
	always @(negedge SCL) begin
		if (cnt == 4'h8)
			sda_oe = !NACK;
		if (cnt == 4'h9) begin
			sda_oe = 1'b0;
			cnt = 4'h0;
			N_BYTES = N_BYTES + 1;
		end
		if (STRETCH) begin
			scl_oe = 1'b1;
			#1500;
			scl_oe = 1'b0;
		end
	end
endmodule

// ==== dv/uart_two_wire_mode_tb.sv ====
`timescale 1ns/100ps

// ==========================================================
// Self-checking bench for the two-wire mode block.
module uart_two_wire_mode_tb;
	logic                      clk     = 1'b0;
	logic                      rstn    = 1'b0;
	two_wire_pkg::bus_req_type bus     = '0;
	logic                      nack    = 1'b0;
	logic                      stretch = 1'b0;
	logic                      gen     = 1'b0;
	logic [7:0]                rdata, seen, d;
	logic                      sda, scl, sda_oe, scl_oe, sck_o, sck_oe;
	logic                      irq_c, irq_t, irq_r, sda_o, scl_o;
	int                        n_bytes, k;
	int                        n_c = 0;
	int                        n_t = 0;
	int                        n_r = 0;
	int                        n_mismatch = 0;
	int                        num_checks = 0;
	int                        seed = 67779;
	logic [7:0] t_ctl [5] = '{8'h00, 8'h00, 8'h01, 8'h03, 8'h00};
	logic       t_nk  [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
	logic       t_st  [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	logic [7:0] t_et  [5] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
	logic [7:0] t_er  [5] = '{8'h01, 8'h00, 8'h01, 8'h01, 8'h01};
	logic [7:0] t_cd  [5] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h28};

	always #5 clk = ~clk;

	always @(posedge clk) begin
		if (irq_c === 1'b1)
			n_c++;
		if (irq_t === 1'b1)
			n_t++;
		if (irq_r === 1'b1)
			n_r++;
	end

	two_wire_mode i_dut (
		.CLK(clk), .RSTN(rstn), .BUS(bus), .RDATA(rdata),
		.DATA_LINE_I(sda), .DATA_LINE_O(sda_o), .DATA_LINE_OE(sda_oe),
		.CLOCK_LINE_I(scl), .CLOCK_LINE_O(scl_o), .CLOCK_LINE_OE(scl_oe),
		.SERIAL_CLOCK_PIN_O(sck_o), .SERIAL_CLOCK_PIN_OE(sck_oe),
		.IRQ_COND(irq_c), .IRQ_TX(irq_t), .IRQ_RX(irq_r)
	);

	two_wire_far_end i_far (
		.DEV_SDA_OE(sda_oe), .DEV_SCL_OE(scl_oe), .NACK(nack),
		.STRETCH(stretch), .BUS_COND(gen), .SDA(sda), .SCL(scl),
		.BYTE(seen),
		.N_BYTES(n_bytes)
	);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 chk(rdata, exp);
	endtask

	// Issues a condition and waits for its completion pulse.
	task automatic cond(input logic [7:0] v, input int lim);
		n_c = 0;
		wr(two_wire_pkg::OFS_COND, v & 8'hF7);
		wr(two_wire_pkg::OFS_COND, v);
		for (int i = 0; i < lim && n_c == 0; i++)
			@(posedge clk);
		repeat (10) @(posedge clk);
	endtask

	task automatic stop_test();
		if (n_mismatch == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#400000;
		n_mismatch++;
		stop_test();
	end

	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		for (int a = 0; a < 8; a++)
			rd(3'(a), two_wire_pkg::RST8);
		for (int a = 6; a < 8; a++) begin
			d = 8'($random(seed));
			wr(3'(a), d);
			rd(3'(a), d);
		end
		wr(two_wire_pkg::OFS_MODE, 8'hA0);
		rd(two_wire_pkg::OFS_MODE, 8'h20);
		cond(8'h09, 300);
		chk(8'(n_c), 8'h00);
		chk({6'h00, scl, sda}, 8'h03);
		wr(two_wire_pkg::OFS_COND, 8'h00);
		wr(two_wire_pkg::OFS_MODE, 8'h2A);
		cond(8'h01, 300);
		chk(8'(n_c), 8'h00);
		chk({6'h00, scl, sda}, 8'h03);
		cond(8'h09, 1000);
		chk(8'(n_c), 8'h01);
		rd(two_wire_pkg::OFS_COND, 8'h08);
		chk({6'h00, scl, sda}, 8'h00);
		chk({6'h00, sck_o, sck_oe}, 8'h00);
		chk({6'h00, sda_o, scl_o}, 8'h00);
		for (int t = 0; t < 5; t++) begin
			d = 8'($random(seed));
			nack <= t_nk[t];
			stretch <= t_st[t];
			wr(two_wire_pkg::OFS_CTL2, t_ctl[t]);
			wr(two_wire_pkg::OFS_COND, t_cd[t]);
			n_t = 0;
			n_r = 0;
			k = n_bytes;
			wr(two_wire_pkg::OFS_TXB, d);
			for (int i = 0; i < 4000 && n_bytes == k; i++)
				@(posedge clk);
			repeat (20) @(posedge clk);
			chk(8'(n_bytes - k), 8'h01);
			chk(seen, d);
			chk(8'(n_t), t_et[t]);
			chk(8'(n_r), t_er[t]);
			rd(two_wire_pkg::OFS_RXB, d);
			d = {7'h02, t_nk[t] & !t_cd[t][5]};
			rd(two_wire_pkg::OFS_RXST, d);
		end
		stretch <= 1'b0;
		wr(two_wire_pkg::OFS_MODE, 8'h3A);
		gen <= 1'b1;
		k = n_bytes;
		wr(two_wire_pkg::OFS_TXB, 8'h5A);
		for (int i = 0; i < 4000 && n_bytes == k; i++)
			@(posedge clk);
		repeat (20) @(posedge clk);
		gen <= 1'b0;
		chk(8'(n_bytes - k), 8'h01);
		chk(seen, 8'h00);
		rd(two_wire_pkg::OFS_RXST, 8'h06);
		wr(two_wire_pkg::OFS_RXST, 8'h00);
		rd(two_wire_pkg::OFS_RXST, 8'h04);
		wr(two_wire_pkg::OFS_MODE, 8'h2A);
		cond(8'h0A, 1000);
		chk(8'(n_c), 8'h01);
		chk({6'h00, scl, sda}, 8'h00);
		cond(8'h0C, 1000);
		chk(8'(n_c), 8'h01);
		chk({6'h00, scl, sda}, 8'h03);
		rd(two_wire_pkg::OFS_RXST, 8'h00);
		wr(two_wire_pkg::OFS_COND, 8'h00);
		n_c = 0;
		gen <= 1'b1;
		repeat (20) @(posedge clk);
		chk(8'(n_c), 8'h01);
		rd(two_wire_pkg::OFS_MODE, 8'hAA);
		n_c = 0;
		gen <= 1'b0;
		repeat (20) @(posedge clk);
		chk(8'(n_c), 8'h01);
		rd(two_wire_pkg::OFS_MODE, 8'h2A);
		stop_test();
	end
endmodule

// ==== verilog/two_wire_mode.sv ====
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/100ps

// Functional notes
// - Channel 2 data pin always open-drain.
// - Master start request makes start condition.
// - Master restart request makes repeated start.
// - Master stop request makes stop condition.
// - Conditions driven only while output select set.
// - Ack value driven when ack output enabled.
// - Master releases clock on stop if enabled.
// - Slave holds clock low from ninth fall.
// - Mode active when field 010 and select set.
// - Condition interrupt on start or stop.
// - Receive interrupt timing follows ack select.
// - Receive buffer load timing follows selects.
// - Data output delayed behind the clock.
// - Data pin is SDA, clock pin SCL.
// - Separate clock pin unused in this mode.
// - Detect start and stop with clock high.
// - Shared condition interrupt, busy flag tells which.
// - Arbitration check on rising clock edges.
module two_wire_mode (
	input  wire logic                      CLK,
	input  wire logic                      RSTN,
	input  wire two_wire_pkg::bus_req_type BUS,
	output logic [7:0]                     RDATA,
	input  wire logic                      DATA_LINE_I,
	output logic                           DATA_LINE_O,
	output logic                           DATA_LINE_OE,
	input  wire logic                      CLOCK_LINE_I,
	output logic                           CLOCK_LINE_O,
	output logic                           CLOCK_LINE_OE,
	output logic                           SERIAL_CLOCK_PIN_O,
	output logic                           SERIAL_CLOCK_PIN_OE,
	output logic                           IRQ_COND,
	output logic                           IRQ_TX,
	output logic                           IRQ_RX
);

	two_wire_pkg::state_type s_r;
	two_wire_pkg::state_type s_nxt;
	logic                    in_mode;
	logic                    master;
	logic                    tick;
	logic                    start_det;
	logic                    stop_det;
	logic                    rise;
	logic                    fall;
	logic                    ack_interrupt_select;
	logic                    clock_delay_select;
	logic                    done;

	// ==========================================================
	// Decodes.
	assign in_mode = s_r.mode[2:0] == two_wire_pkg::SMD_TWO_WIRE
		&& s_r.mode[two_wire_pkg::B_TWO_WIRE_MODE_SELECT];
	assign master = s_r.mode[two_wire_pkg::B_MST];
	assign ack_interrupt_select = s_r.ctl2[two_wire_pkg::B_ACK_INTERRUPT_SELECT];
	assign clock_delay_select = s_r.ctl2[two_wire_pkg::B_CLOCK_DELAY_SELECT];
	assign tick = s_r.div == two_wire_pkg::HALF_CYC - 8'h01;
	assign start_det = s_r.scl_s2 && s_r.scl_d
		&& s_r.sda_d && !s_r.sda_s2;
	assign stop_det = s_r.scl_s2 && s_r.scl_d
		&& !s_r.sda_d && s_r.sda_s2;
	assign rise = s_r.scl_s2 && !s_r.scl_d && s_r.ph == two_wire_pkg::PH_XFER;
	assign fall = !s_r.scl_s2 && s_r.scl_d && s_r.ph == two_wire_pkg::PH_XFER;

	// ==========================================================
	// Next state.
	always_comb begin
		s_nxt = s_r;
		done = 1'b0;
		s_nxt.irq_cond = 1'b0;
		s_nxt.irq_tx = 1'b0;
		s_nxt.irq_rx = 1'b0;
		s_nxt.sda_s1 = DATA_LINE_I;
		s_nxt.sda_s2 = s_r.sda_s1;
		s_nxt.sda_d = s_r.sda_s2;
		s_nxt.scl_s1 = CLOCK_LINE_I;
		s_nxt.scl_s2 = s_r.scl_s1;
		s_nxt.scl_d = s_r.scl_s2;
		s_nxt.div = tick ? two_wire_pkg::RST8 : s_r.div + 8'h01;
		s_nxt.rdata = two_wire_pkg::RST8;
		if (BUS.rd) begin
			case (BUS.addr)
				two_wire_pkg::OFS_MODE: begin
					s_nxt.rdata = s_r.mode;
					s_nxt.rdata[two_wire_pkg::B_BBS] = s_r.bus_busy_flag;
				end
				two_wire_pkg::OFS_CTL2: s_nxt.rdata = s_r.ctl2;
				two_wire_pkg::OFS_COND: s_nxt.rdata = s_r.cond;
				two_wire_pkg::OFS_TXB: s_nxt.rdata = s_r.txb;
				two_wire_pkg::OFS_RXB: s_nxt.rdata = s_r.rxb;
				two_wire_pkg::OFS_RXST: begin
					s_nxt.rdata[two_wire_pkg::B_RACK] = s_r.rx_ack;
					s_nxt.rdata[two_wire_pkg::B_ABT] = s_r.arbitration_lost_flag;
					s_nxt.rdata[two_wire_pkg::B_RBBS] = s_r.bus_busy_flag;
				end
				two_wire_pkg::OFS_ISEL: s_nxt.rdata = s_r.isel;
				two_wire_pkg::OFS_SHARED: s_nxt.rdata = s_r.shared;
				default: s_nxt.rdata = two_wire_pkg::RST8;
			endcase
		end
		if (BUS.wr) begin
			case (BUS.addr)
				two_wire_pkg::OFS_MODE: begin
					s_nxt.mode = BUS.wdata;
					s_nxt.mode[two_wire_pkg::B_BBS] = 1'b0;
				end
				two_wire_pkg::OFS_CTL2: s_nxt.ctl2 = BUS.wdata;
				two_wire_pkg::OFS_COND: begin
					s_nxt.cond = BUS.wdata;
					if (!BUS.wdata[two_wire_pkg::B_NINTH_CLOCK_HOLD]) begin
						s_nxt.hold = 1'b0;
					end
				end
				two_wire_pkg::OFS_TXB: begin
					s_nxt.txb = BUS.wdata;
					s_nxt.hold = 1'b0;
					if (in_mode && s_r.ph == two_wire_pkg::PH_IDLE) begin
						s_nxt.ph = two_wire_pkg::PH_XFER;
						s_nxt.cnt = 4'h0;
						s_nxt.mism = 1'b0;
						s_nxt.pend_val = BUS.wdata[7];
						s_nxt.dly = two_wire_pkg::DLY_CYC;
					end
				end
				two_wire_pkg::OFS_RXST: s_nxt.arbitration_lost_flag = 1'b0;
				two_wire_pkg::OFS_ISEL: s_nxt.isel = BUS.wdata;
				two_wire_pkg::OFS_SHARED: s_nxt.shared = BUS.wdata;
				default: s_nxt.rdata = s_nxt.rdata;
			endcase
		end
		if (s_r.dly != 3'h0) begin
			s_nxt.dly = s_r.dly - 3'h1;
			if (s_r.dly == 3'h1) begin
				s_nxt.sda_drv = !s_r.pend_val;
			end
		end
		case (s_r.ph)
			two_wire_pkg::PH_IDLE: begin
				if (in_mode && master && s_r.cond[two_wire_pkg::B_SEL]
					&& s_r.cond[two_wire_pkg::B_STP:two_wire_pkg::B_STA]
					!= 3'h0) begin
					if (s_r.cond[two_wire_pkg::B_STA]) begin
						s_nxt.ph = two_wire_pkg::PH_CB;
					end else begin
						s_nxt.ph = two_wire_pkg::PH_CA;
					end
				end
			end
			two_wire_pkg::PH_CA: if (tick) begin
				s_nxt.scl_drv = 1'b1;
				s_nxt.sda_drv = s_r.cond[two_wire_pkg::B_STP];
				s_nxt.ph = two_wire_pkg::PH_CB;
			end
			two_wire_pkg::PH_CB: if (tick) begin
				s_nxt.scl_drv = 1'b0;
				s_nxt.ph = two_wire_pkg::PH_CC;
			end
			two_wire_pkg::PH_CC: if (tick) begin
				if (s_r.cond[two_wire_pkg::B_STP]) begin
					s_nxt.sda_drv = 1'b0;
					done = 1'b1;
				end else begin
					s_nxt.sda_drv = 1'b1;
					s_nxt.ph = two_wire_pkg::PH_CD;
				end
			end
			two_wire_pkg::PH_CD: if (tick) begin
				s_nxt.scl_drv = 1'b1;
				done = 1'b1;
			end
			two_wire_pkg::PH_XFER: begin
				if (master && tick) begin
					// The clock is released only once the data bit stands.
					if (s_r.scl_drv) begin
						if (s_r.dly == 3'h0) begin
							s_nxt.scl_drv = 1'b0;
						end
					end else if (s_r.scl_s2) begin
						s_nxt.scl_drv = 1'b1;
					end
				end
				if (rise) begin
					s_nxt.cnt = s_r.cnt + 4'h1;
					if (s_r.cnt < two_wire_pkg::BITS_DATA) begin
						s_nxt.sh = {s_r.sh[6:0], s_r.sda_s2};
						if (master && !s_r.sda_drv && !s_r.sda_s2) begin
							s_nxt.mism = 1'b1;
						end
						if (master && !s_r.mode[two_wire_pkg::B_ABC]) begin
							s_nxt.arbitration_lost_flag = !s_r.sda_drv && !s_r.sda_s2;
						end
					end else begin
						s_nxt.rx_ack = s_r.sda_s2;
						if (!ack_interrupt_select) begin
							s_nxt.irq_tx = s_r.sda_s2;
							s_nxt.irq_rx = !s_r.sda_s2;
						end else if (!clock_delay_select) begin
							s_nxt.irq_tx = 1'b1;
						end
						if (!ack_interrupt_select || clock_delay_select) begin
							s_nxt.rxb = s_r.sh;
						end
					end
				end
				if (fall) begin
					if (s_r.cnt == two_wire_pkg::BITS_ALL) begin
						s_nxt.ph = two_wire_pkg::PH_IDLE;
						s_nxt.pend_val = 1'b1;
						s_nxt.dly = two_wire_pkg::DLY_CYC;
						if (ack_interrupt_select) begin
							s_nxt.irq_rx = 1'b1;
							s_nxt.irq_tx = clock_delay_select;
							if (!clock_delay_select) begin
								s_nxt.rxb = s_r.sh;
							end
						end
						if (master && s_r.mode[two_wire_pkg::B_ABC] && s_r.mism) begin
							s_nxt.arbitration_lost_flag = 1'b1;
						end
						if (!master && s_r.cond[two_wire_pkg::B_NINTH_CLOCK_HOLD]) begin
							s_nxt.hold = 1'b1;
						end
					end else begin
						if (s_r.cnt == two_wire_pkg::BITS_DATA) begin
							s_nxt.pend_val = !s_r.cond[two_wire_pkg::B_ACK_OUTPUT_ENABLE]
								|| s_r.cond[two_wire_pkg::B_ACK_VALUE_SELECT];
							if (ack_interrupt_select && clock_delay_select) begin
								s_nxt.rxb = s_r.sh;
							end
						end else begin
							s_nxt.pend_val = s_r.txb[3'h7 - s_r.cnt[2:0]];
						end
						s_nxt.dly = two_wire_pkg::DLY_CYC;
					end
				end
			end
			default: s_nxt.ph = two_wire_pkg::PH_IDLE;
		endcase
		if (done) begin
			s_nxt.ph = two_wire_pkg::PH_IDLE;
			s_nxt.cond[two_wire_pkg::B_STP:two_wire_pkg::B_STA] = 3'h0;
			s_nxt.irq_cond = 1'b1;
		end
		if (start_det) begin
			s_nxt.bus_busy_flag = 1'b1;
			if (!s_r.cond[two_wire_pkg::B_SEL]) begin
				s_nxt.irq_cond = 1'b1;
			end
		end else if (stop_det) begin
			s_nxt.bus_busy_flag = 1'b0;
			if (!s_r.cond[two_wire_pkg::B_SEL]) begin
				s_nxt.irq_cond = 1'b1;
			end
			if (master && s_r.cond[two_wire_pkg::B_CLOCK_STOP_ON_STOP]
				&& s_r.ph == two_wire_pkg::PH_XFER) begin
				s_nxt.scl_drv = 1'b0;
				s_nxt.ph = two_wire_pkg::PH_IDLE;
			end
		end
		if (!in_mode) begin
			s_nxt.ph = two_wire_pkg::PH_IDLE;
			s_nxt.scl_drv = 1'b0;
			s_nxt.sda_drv = 1'b0;
			s_nxt.hold = 1'b0;
			s_nxt.dly = 3'h0;
		end
		s_nxt.sda_oe = in_mode && s_nxt.sda_drv;
		s_nxt.scl_oe = in_mode && (s_nxt.scl_drv || s_nxt.hold);
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs.
	assign RDATA = s_r.rdata;
	assign DATA_LINE_O = 1'b0;
	assign DATA_LINE_OE = s_r.sda_oe;
	assign CLOCK_LINE_O = 1'b0;
	assign CLOCK_LINE_OE = s_r.scl_oe;
	assign SERIAL_CLOCK_PIN_O = 1'b0;
	assign SERIAL_CLOCK_PIN_OE = 1'b0;
	assign IRQ_COND = s_r.irq_cond;
	assign IRQ_TX = s_r.irq_tx;
	assign IRQ_RX = s_r.irq_rx;

	// ==========================================================
	// Checks.
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);

	bbs_start_a: assert property (start_det |=> s_r.bus_busy_flag)
		else $error("Busy flag not set by start.");
	bbs_stop_a: assert property (stop_det && !start_det |=> !s_r.bus_busy_flag)
		else $error("Busy flag not cleared by stop.");
	cond_irq_a: assert property (start_det && !s_r.cond[two_wire_pkg::B_SEL]
		|=> IRQ_COND) else $error("No condition interrupt.");
	nack_irq_a: assert property (rise && s_r.cnt == two_wire_pkg::BITS_DATA
		&& !ack_interrupt_select && s_r.sda_s2 |=> IRQ_TX && !IRQ_RX)
		else $error("No not-acknowledge interrupt.");
	ack_irq_a: assert property (rise && s_r.cnt == two_wire_pkg::BITS_DATA
		&& !ack_interrupt_select && !s_r.sda_s2 |=> IRQ_RX && !s_r.rx_ack)
		else $error("No acknowledge interrupt.");
	rx_copy_a: assert property (rise && s_r.cnt == two_wire_pkg::BITS_DATA
		&& !ack_interrupt_select |=> s_r.rxb == $past(s_r.sh))
		else $error("Receive buffer not loaded.");
	hold_a: assert property (fall && s_r.cnt == two_wire_pkg::BITS_ALL && in_mode
		&& !master && s_r.cond[two_wire_pkg::B_NINTH_CLOCK_HOLD] |=> ##1 CLOCK_LINE_OE)
		else $error("Clock line not held.");
	mode_a: assert property (!in_mode |=> !DATA_LINE_OE && !CLOCK_LINE_OE)
		else $error("Line driven outside mode.");
	stopclk_a: assert property (stop_det && master && in_mode
		&& s_r.cond[two_wire_pkg::B_CLOCK_STOP_ON_STOP] && s_r.ph == two_wire_pkg::PH_XFER
		|=> s_r.ph == two_wire_pkg::PH_IDLE ##1 !CLOCK_LINE_OE)
		else $error("Clock not released on stop.");

endmodule

// ==== verilog/two_wire_pkg.sv ====
package two_wire_pkg;

	// ==========================================================
	// Timing.
	localparam int          CLK_MHZ  = 100;
	localparam int          HALF_NS  = 500;
	localparam logic [7:0]  HALF_CYC = 8'((HALF_NS * CLK_MHZ + 999) / 1000);
	localparam int          DLY_NS   = 30;
	localparam logic [2:0]  DLY_CYC  = 3'((DLY_NS * CLK_MHZ + 999) / 1000);

	// ==========================================================
	// Register offsets.
	localparam logic [2:0]  OFS_MODE   = 3'h0;
	localparam logic [2:0]  OFS_CTL2   = 3'h1;
	localparam logic [2:0]  OFS_COND   = 3'h2;
	localparam logic [2:0]  OFS_TXB    = 3'h3;
	localparam logic [2:0]  OFS_RXB    = 3'h4;
	localparam logic [2:0]  OFS_RXST   = 3'h5;
	localparam logic [2:0]  OFS_ISEL   = 3'h6;
	localparam logic [2:0]  OFS_SHARED = 3'h7;

	// ==========================================================
	// Field positions and values.
	localparam logic [2:0]  SMD_TWO_WIRE = 3'h2;
	localparam int          B_TWO_WIRE_MODE_SELECT  = 3;
	localparam int          B_ABC   = 4;
	localparam int          B_MST   = 5;
	localparam int          B_BBS   = 7;
	localparam int          B_ACK_INTERRUPT_SELECT = 0;
	localparam int          B_CLOCK_DELAY_SELECT  = 1;
	localparam int          B_STA   = 0;
	localparam int          B_RSTA  = 1;
	localparam int          B_STP   = 2;
	localparam int          B_SEL   = 3;
	localparam int          B_ACK_VALUE_SELECT  = 4;
	localparam int          B_ACK_OUTPUT_ENABLE  = 5;
	localparam int          B_CLOCK_STOP_ON_STOP = 6;
	localparam int          B_NINTH_CLOCK_HOLD  = 7;
	localparam int          B_RACK  = 0;
	localparam int          B_ABT   = 1;
	localparam int          B_RBBS  = 2;
	localparam logic [7:0]  RST8      = 8'h00;
	localparam logic [3:0]  BITS_DATA = 4'h8;
	localparam logic [3:0]  BITS_ALL  = 4'h9;

	// ==========================================================
	// Types.
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_CA   = 3'b001,
		PH_CB   = 3'b010,
		PH_CC   = 3'b011,
		PH_CD   = 3'b100,
		PH_XFER = 3'b101
	} phase_type;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_type;

	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] ctl2;
		logic [7:0] cond;
		logic [7:0] txb;
		logic [7:0] rxb;
		logic [7:0] isel;
		logic [7:0] shared;
		logic [7:0] rdata;
		logic [7:0] sh;
		logic [7:0] div;
		logic [3:0] cnt;
		logic [2:0] dly;
		phase_type  ph;
		logic       rx_ack;
		logic       arbitration_lost_flag;
		logic       mism;
		logic       bus_busy_flag;
		logic       hold;
		logic       scl_drv;
		logic       sda_drv;
		logic       pend_val;
		logic       sda_s1;
		logic       sda_s2;
		logic       sda_d;
		logic       scl_s1;
		logic       scl_s2;
		logic       scl_d;
		logic       irq_cond;
		logic       irq_tx;
		logic       irq_rx;
		logic       sda_oe;
		logic       scl_oe;
	} state_type;

endpackage
